// ### shared/ufdc_pkg.sv
package ufdc_pkg;

  // Default FIFO depth in characters.
  localparam int DEPTH = 64;

  // Register byte offsets.
  localparam logic [7:0] ADDR_HOLD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TXCNT = 8'h08;
  localparam logic [7:0] ADDR_RXCNT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_CLR = 8'h14;
  localparam logic [7:0] ADDR_IEN = 8'h18;
  localparam logic [7:0] ADDR_FLAG = 8'h1c;

  // Control register field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RXCLR_BIT = 1;
  localparam int CTRL_TXCLR_BIT = 2;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_TXTRIG_LSB = 4;
  localparam int CTRL_RXTRIG_LSB = 6;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] IEN_RESET = 5'h00;

  // Trigger levels in characters.
  localparam logic [6:0] RX_TRIG_0 = 7'h08;
  localparam logic [6:0] RX_TRIG_1 = 7'h10;
  localparam logic [6:0] RX_TRIG_2 = 7'h38;
  localparam logic [6:0] RX_TRIG_3 = 7'h3c;
  localparam logic [6:0] TX_TRIG_0 = 7'h08;
  localparam logic [6:0] TX_TRIG_1 = 7'h10;
  localparam logic [6:0] TX_TRIG_2 = 7'h20;
  localparam logic [6:0] TX_TRIG_3 = 7'h38;

  // Event bit positions in the status, clear and enable registers.
  localparam int EV_RX_LEVEL = 0;
  localparam int EV_TX_LEVEL = 1;
  localparam int EV_RX_TMO = 2;
  localparam int EV_RX_OVR = 3;
  localparam int EV_TX_OVR = 4;
  localparam int EV_W = 5;

  // One register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ufdc_bus_t;

  // Request line state.
  typedef enum logic [1:0] {
    UFDC_REQ_IDLE   = 2'b01,
    UFDC_REQ_ACTIVE = 2'b10
  } ufdc_req_st_t;

endpackage

// ### core/ufdc_core.sv
// What this block does
// - Mode 0: tx request low when tx FIFO empty.
// - Mode 0: rx request low when char held.
// - Mode 1: tx interrupt while below trigger.
// - Mode 1: tx request low until full.
// - Mode 1: rx interrupt at trigger, keep filling.
// - Mode 1: rx request low until empty.
// - Rx interrupt at trigger count equality.
// - Tx interrupt when count below trigger.
// - Control bit 3 selects mode, reset 0.
// - Mode 0 tx request low when empty.
// - Mode 0 rx request low while nonempty.
// - Bit 2 clears tx FIFO, self-clears.
// - Bit 1 clears rx FIFO, self-clears.
// - Bit 0 enables both FIFOs, reset off.
// - Other bits written only with bit 0.
// - Bits 7:6 pick rx trigger 8/16/56/60.
// - Bits 5:4 pick tx trigger 8/16/32/56.
//
// Our own choices: the register addresses and strobed register access.
module ufdc_core #(
  parameter int DEPTH = ufdc_pkg::DEPTH
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire ufdc_pkg::ufdc_bus_t bus_i,
  output logic [7:0]             rdata_o,
  input  wire logic              tx_pop_i,
  output logic [7:0]             tx_data_o,
  output logic                   tx_avail_o,
  input  wire logic              rx_push_i,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic              rx_timeout_i,
  output logic                   tx_irq_o,
  output logic                   rx_irq_o,
  output logic                   tx_request_n_o,
  output logic                   rx_request_n_o,
  output logic                   irq_o
);

  // Pointer and count widths.
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  // Decodes a trigger select into a character count.
  function automatic logic [CW-1:0] trig_level(
    input logic [1:0] sel,
    input logic       is_rx
  );
    logic [6:0] lvl;
    lvl = 7'h00;
    unique case (sel)
      2'b00: lvl = is_rx ? ufdc_pkg::RX_TRIG_0 : ufdc_pkg::TX_TRIG_0;
      2'b01: lvl = is_rx ? ufdc_pkg::RX_TRIG_1 : ufdc_pkg::TX_TRIG_1;
      2'b10: lvl = is_rx ? ufdc_pkg::RX_TRIG_2 : ufdc_pkg::TX_TRIG_2;
      2'b11: lvl = is_rx ? ufdc_pkg::RX_TRIG_3 : ufdc_pkg::TX_TRIG_3;
    endcase
    return CW'(lvl);
  endfunction

  // Updates a FIFO count by one push and one pop.
  function automatic logic [CW-1:0] count_step(
    input logic [CW-1:0] cnt,
    input logic          push,
    input logic          pop
  );
    return CW'(cnt + CW'(push) - CW'(pop));
  endfunction

  // Configuration fields held from the control register.
  logic                   fifo_en_reg;  // FIFOs enabled.
  logic                   mode_reg;     // DMA signalling mode.
  logic [1:0]             rx_sel_reg;   // Rx trigger select.
  logic [1:0]             tx_sel_reg;   // Tx trigger select.

  // FIFO storage, pointers and counts.
  logic [7:0]             tx_mem [DEPTH];
  logic [7:0]             rx_mem [DEPTH];
  logic [AW-1:0]          tx_wp_reg, tx_rp_reg;
  logic [AW-1:0]          rx_wp_reg, rx_rp_reg;
  logic [CW-1:0]          tx_cnt_reg, rx_cnt_reg;
  logic [CW-1:0]          tx_cnt_next, rx_cnt_next;

  // Request state, output data and interrupt registers.
  ufdc_pkg::ufdc_req_st_t tx_st_reg, tx_st_next;
  ufdc_pkg::ufdc_req_st_t rx_st_reg, rx_st_next;
  logic [7:0]             rdata_reg;
  logic [7:0]             tx_data_reg;
  logic                   tx_lvl_reg, rx_lvl_reg;
  logic [ufdc_pkg::EV_W-1:0] stat_reg, stat_next;
  logic [ufdc_pkg::EV_W-1:0] ien_reg;

  // Bus decode.
  wire hold_wr = bus_i.wr && (bus_i.addr == ufdc_pkg::ADDR_HOLD);
  wire hold_rd = bus_i.rd && (bus_i.addr == ufdc_pkg::ADDR_HOLD);
  wire ctrl_wr = bus_i.wr && (bus_i.addr == ufdc_pkg::ADDR_CTRL);
  wire clr_wr  = bus_i.wr && (bus_i.addr == ufdc_pkg::ADDR_CLR);
  wire ien_wr  = bus_i.wr && (bus_i.addr == ufdc_pkg::ADDR_IEN);

  // Fields other than the enable only land with bit 0 set.
  wire cfg_wr = ctrl_wr && bus_i.wdata[ufdc_pkg::CTRL_EN_BIT];

  // Toggling the enable flushes both FIFOs so depth stays consistent.
  wire en_flip = ctrl_wr &&
    (bus_i.wdata[ufdc_pkg::CTRL_EN_BIT] != fifo_en_reg);

  // Self-clearing flush strobes; never stored.
  wire tx_clear = en_flip ||
    (cfg_wr && bus_i.wdata[ufdc_pkg::CTRL_TXCLR_BIT]);
  wire rx_clear = en_flip ||
    (cfg_wr && bus_i.wdata[ufdc_pkg::CTRL_RXCLR_BIT]);

  // Disabled FIFOs act as a single holding register.
  wire [CW-1:0] limit = fifo_en_reg ? CW'(DEPTH) : CW'(1);

  // Fill conditions.
  wire tx_full  = (tx_cnt_reg >= limit);
  wire rx_full  = (rx_cnt_reg >= limit);
  wire tx_empty = (tx_cnt_reg == '0);
  wire rx_empty = (rx_cnt_reg == '0);

  // Accepted transfers; a push into a full FIFO is dropped.
  wire tx_push = hold_wr && !tx_full;
  wire tx_pop  = tx_pop_i && !tx_empty;
  wire rx_push = rx_push_i && !rx_full;
  wire rx_pop  = hold_rd && !rx_empty;

  // Trigger levels.
  wire [CW-1:0] rx_trig = trig_level(rx_sel_reg, 1'b1);
  wire [CW-1:0] tx_trig = trig_level(tx_sel_reg, 1'b0);

  // Block signalling applies only with FIFOs on and mode 1.
  wire m1 = fifo_en_reg && mode_reg;

  // Interrupt request levels toward the rest of the UART.
  wire tx_lvl = fifo_en_reg ? (tx_cnt_reg < tx_trig) : tx_empty;
  wire rx_lvl = fifo_en_reg ? (rx_cnt_reg >= rx_trig)
                            : !rx_empty;

  // Conditions that start a mode 1 request.
  wire tx_set = (tx_cnt_reg < tx_trig);
  wire rx_set = (rx_cnt_reg >= rx_trig) || rx_timeout_i;

  // Events for the sticky status register.
  wire [ufdc_pkg::EV_W-1:0] ev = {
    hold_wr && tx_full,
    rx_push_i && rx_full,
    rx_timeout_i,
    tx_lvl && !tx_lvl_reg,
    rx_lvl && !rx_lvl_reg
  };

  // Software clear mask.
  wire [ufdc_pkg::EV_W-1:0] clr_mask =
    clr_wr ? bus_i.wdata[ufdc_pkg::EV_W-1:0] : '0;

  // Read multiplexer.
  wire [7:0] ctrl_rd = {rx_sel_reg, tx_sel_reg, mode_reg, 2'b00,
                        fifo_en_reg};
  wire [7:0] flag_rd = {4'h0, !rx_request_n_o, !tx_request_n_o,
                        rx_irq_o, tx_irq_o};
  wire [7:0] rx_head = rx_empty ? 8'h00 : rx_mem[rx_rp_reg];
  wire [7:0] rd_mux =
    (bus_i.addr == ufdc_pkg::ADDR_HOLD)  ? rx_head :
    (bus_i.addr == ufdc_pkg::ADDR_CTRL)  ? ctrl_rd :
    (bus_i.addr == ufdc_pkg::ADDR_TXCNT) ? 8'(tx_cnt_reg) :
    (bus_i.addr == ufdc_pkg::ADDR_RXCNT) ? 8'(rx_cnt_reg) :
    (bus_i.addr == ufdc_pkg::ADDR_STAT)  ? 8'(stat_reg) :
    (bus_i.addr == ufdc_pkg::ADDR_IEN)   ? 8'(ien_reg) :
    (bus_i.addr == ufdc_pkg::ADDR_FLAG)  ? flag_rd : 8'h00;

  // Next counts; a flush wins over a same-cycle transfer.
  assign tx_cnt_next = tx_clear ? '0 : count_step(tx_cnt_reg, tx_push,
                                                  tx_pop);
  assign rx_cnt_next = rx_clear ? '0 : count_step(rx_cnt_reg, rx_push,
                                                  rx_pop);

  // Hardware set wins over a software clear.
  assign stat_next = (stat_reg & ~clr_mask) | ev;

  // Tx request state: armed below trigger, released when full.
  always_comb begin
    tx_st_next = tx_st_reg;
    unique case (tx_st_reg)
      ufdc_pkg::UFDC_REQ_IDLE: begin
        if (m1 && tx_set) begin
          tx_st_next = ufdc_pkg::UFDC_REQ_ACTIVE;
        end
      end
      ufdc_pkg::UFDC_REQ_ACTIVE: begin
        if (!m1 || tx_full) begin
          tx_st_next = ufdc_pkg::UFDC_REQ_IDLE;
        end
      end
      default: begin
        tx_st_next = ufdc_pkg::UFDC_REQ_IDLE;
      end
    endcase
  end

  // Rx request state: armed at trigger or time-out, released on empty.
  always_comb begin
    rx_st_next = rx_st_reg;
    unique case (rx_st_reg)
      ufdc_pkg::UFDC_REQ_IDLE: begin
        if (m1 && rx_set && !rx_empty) begin
          rx_st_next = ufdc_pkg::UFDC_REQ_ACTIVE;
        end
      end
      ufdc_pkg::UFDC_REQ_ACTIVE: begin
        if (!m1 || rx_empty) begin
          rx_st_next = ufdc_pkg::UFDC_REQ_IDLE;
        end
      end
      default: begin
        rx_st_next = ufdc_pkg::UFDC_REQ_IDLE;
      end
    endcase
  end

  // Request lines, combinational from state and counts.
  assign tx_request_n_o = m1
    ? !(((tx_st_reg == ufdc_pkg::UFDC_REQ_ACTIVE) || tx_set) &&
        !tx_full)
    : !tx_empty;
  assign rx_request_n_o = m1
    ? !(((rx_st_reg == ufdc_pkg::UFDC_REQ_ACTIVE) || rx_set) &&
        !rx_empty)
    : rx_empty;

  // Remaining outputs.
  assign tx_irq_o   = tx_lvl;
  assign rx_irq_o   = rx_lvl;
  assign tx_avail_o = !tx_empty;
  assign rdata_o    = rdata_reg;
  assign tx_data_o  = tx_data_reg;
  assign irq_o      = |(stat_reg & ien_reg);

  // Control register fields.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fifo_en_reg <= ufdc_pkg::CTRL_RESET[ufdc_pkg::CTRL_EN_BIT];
      mode_reg    <= ufdc_pkg::CTRL_RESET[ufdc_pkg::CTRL_MODE_BIT];
      tx_sel_reg  <= ufdc_pkg::CTRL_RESET[5:4];
      rx_sel_reg  <= ufdc_pkg::CTRL_RESET[7:6];
    end else if (ce_i && ctrl_wr) begin
      fifo_en_reg <= bus_i.wdata[ufdc_pkg::CTRL_EN_BIT];
      if (cfg_wr) begin
        mode_reg   <= bus_i.wdata[ufdc_pkg::CTRL_MODE_BIT];
        tx_sel_reg <= bus_i.wdata[ufdc_pkg::CTRL_TXTRIG_LSB +: 2];
        rx_sel_reg <= bus_i.wdata[ufdc_pkg::CTRL_RXTRIG_LSB +: 2];
      end
    end
  end

  // FIFO counts and pointers.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
    end else if (ce_i) begin
      tx_cnt_reg <= tx_cnt_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_wp_reg  <= tx_clear ? '0 : AW'(tx_wp_reg + AW'(tx_push));
      tx_rp_reg  <= tx_clear ? '0 : AW'(tx_rp_reg + AW'(tx_pop));
      rx_wp_reg  <= rx_clear ? '0 : AW'(rx_wp_reg + AW'(rx_push));
      rx_rp_reg  <= rx_clear ? '0 : AW'(rx_rp_reg + AW'(rx_pop));
    end
  end

  // Character storage; needs no reset since counts guard it.
  always_ff @(posedge clk_i) begin
    if (ce_i && tx_push && !tx_clear) begin
      tx_mem[tx_wp_reg] <= bus_i.wdata;
    end
    if (ce_i && rx_push && !rx_clear) begin
      rx_mem[rx_wp_reg] <= rx_data_i;
    end
  end

  // Request states, read data and character to the shifter.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_st_reg   <= ufdc_pkg::UFDC_REQ_IDLE;
      rx_st_reg   <= ufdc_pkg::UFDC_REQ_IDLE;
      rdata_reg   <= 8'h00;
      tx_data_reg <= 8'h00;
    end else if (ce_i) begin
      tx_st_reg <= tx_st_next;
      rx_st_reg <= rx_st_next;
      rdata_reg <= bus_i.rd ? rd_mux : 8'h00;
      if (tx_pop) begin
        tx_data_reg <= tx_mem[tx_rp_reg];
      end
    end
  end

  // Interrupt status and enable.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      stat_reg   <= '0;
      ien_reg    <= ufdc_pkg::IEN_RESET;
      tx_lvl_reg <= 1'b1; // Empty tx side idles high; no false edge.
      rx_lvl_reg <= 1'b0;
    end else if (ce_i) begin
      stat_reg   <= stat_next;
      tx_lvl_reg <= tx_lvl;
      rx_lvl_reg <= rx_lvl;
      if (ien_wr) begin
        ien_reg <= bus_i.wdata[ufdc_pkg::EV_W-1:0];
      end
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // A write that carries a flush strobe.
  sequence tx_flush_s;
    ce_i && tx_clear;
  endsequence

  sequence rx_flush_s;
    ce_i && rx_clear;
  endsequence

  mode0_tx_a: assert property (
    !m1 |-> (tx_request_n_o == (tx_cnt_reg != '0)))
    else $error("Mode 0 tx request wrong.");

  mode0_rx_a: assert property (
    !m1 |-> (rx_request_n_o == (rx_cnt_reg == '0)))
    else $error("Mode 0 rx request wrong.");

  tx_irq_lvl_a: assert property (
    fifo_en_reg |-> (tx_irq_o == (tx_cnt_reg < tx_trig)))
    else $error("Tx interrupt level wrong.");

  tx_full_rel_a: assert property (
    (m1 && tx_cnt_reg == CW'(DEPTH)) |-> tx_request_n_o)
    else $error("Tx request low while full.");

  tx_armed_a: assert property (
    (m1 && ce_i && tx_set && !tx_full) ##1 (m1 && !tx_full &&
      $stable(tx_sel_reg)) |-> !tx_request_n_o)
    else $error("Tx request released early.");

  rx_equal_a: assert property (
    (fifo_en_reg && rx_cnt_reg == rx_trig) |-> rx_irq_o)
    else $error("Rx interrupt missing at trigger.");

  rx_empty_rel_a: assert property (
    (m1 && rx_cnt_reg == '0) |-> rx_request_n_o)
    else $error("Rx request low while empty.");

  rx_hold_a: assert property (
    (m1 && ce_i && !rx_request_n_o) ##1 (m1 && !rx_empty)
      |-> !rx_request_n_o)
    else $error("Rx request released before empty.");

  rx_fill_a: assert property (
    (ce_i && rx_push_i && !rx_clear && !rx_pop &&
      rx_cnt_reg < limit) |=> (rx_cnt_reg == $past(rx_cnt_reg) + 1'b1))
    else $error("Rx FIFO did not accept character.");

  tx_flush_a: assert property (
    tx_flush_s |=> (tx_cnt_reg == '0) && !tx_request_n_o)
    else $error("Tx flush failed.");

  rx_flush_a: assert property (
    rx_flush_s |=> (rx_cnt_reg == '0) && rx_request_n_o)
    else $error("Rx flush failed.");

  mode_guard_a: assert property (
    (ce_i && ctrl_wr && !bus_i.wdata[0]) |=> $stable(mode_reg) &&
      $stable(rx_sel_reg) && $stable(tx_sel_reg))
    else $error("Control field written without enable.");

  mode_write_a: assert property (
    (ce_i && cfg_wr) |=> (mode_reg == $past(bus_i.wdata[3])))
    else $error("Mode select not stored.");

  rx_trig_a: assert property (
    (rx_sel_reg == 2'b10) |-> (rx_trig == CW'(56)))
    else $error("Rx trigger decode wrong.");

  tx_trig_a: assert property (
    (tx_sel_reg == 2'b10) |-> (tx_trig == CW'(32)))
    else $error("Tx trigger decode wrong.");

  depth_cap_a: assert property (
    (tx_cnt_reg <= CW'(DEPTH)) && (rx_cnt_reg <= CW'(DEPTH)))
    else $error("FIFO count above depth.");

  sticky_set_a: assert property (
    (ce_i && ev[ufdc_pkg::EV_RX_TMO]) |=> stat_reg[ufdc_pkg::EV_RX_TMO])
    else $error("Event lost against clear.");

endmodule

// ### verification/ufdc_host_model.sv
// Host side of the register bus: one strobe per access, never waits.
module ufdc_host_model (
  input  wire logic           clk_i,
  output ufdc_pkg::ufdc_bus_t bus_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus idles with both strobes low.
  initial begin
    bus_o = '0;
  end

  // One access: strobe after an edge, drop it at the taking edge.
  task automatic cycle(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_i);
    bus_o <= '0;
  endtask

  // Control writes through this task always carry the enable bit.
  task automatic set_ctrl(input logic [7:0] v);
    cycle(ufdc_pkg::ADDR_CTRL, v | 8'h01, 1'b1);
  endtask
endmodule

// ### verification/uart_fifo_dma_control_bench.sv
// Bench for the FIFO control block; reads are scored from a queue.
module uart_fifo_dma_control_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk_i, nrst_i, ce_i, tx_pop_i;
  logic                rx_push_i, rx_timeout_i;
  logic                rd_d = 1'b0;
  logic [7:0]          rx_data_i, rdata_o, tx_data_o;
  logic                tx_avail_o, tx_irq_o, rx_irq_o, irq_o;
  logic                tx_request_n_o, rx_request_n_o;
  ufdc_pkg::ufdc_bus_t bus;
  logic [7:0]          exp_q[$], rxq[$], txq[$];
  int                  error_cnt, check_count;
  int                  rxtrig[4] = '{8, 16, 56, 60};
  int                  txtrig[4] = '{8, 16, 32, 56};

  ufdc_host_model u_ufdc_host_model (.clk_i(clk_i), .bus_o(bus));

  ufdc_core u_ufdc_core (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .bus_i(bus),
    .rdata_o(rdata_o), .tx_pop_i(tx_pop_i), .tx_data_o(tx_data_o),
    .tx_avail_o(tx_avail_o), .rx_push_i(rx_push_i),
    .rx_data_i(rx_data_i), .rx_timeout_i(rx_timeout_i),
    .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .tx_request_n_o(tx_request_n_o), .rx_request_n_o(rx_request_n_o),
    .irq_o(irq_o)
  );

  // Free running 250 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic fail(input string m);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      fail(m);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Levels {irq, tx_irq, rx_irq, tx_req_n, rx_req_n}, seen mid-cycle.
  task automatic lv(input logic [4:0] e);
    @(negedge clk_i);
    cmp({3'h0, irq_o, tx_irq_o, rx_irq_o, tx_request_n_o,
         rx_request_n_o}, {3'h0, e}, "levels");
  endtask

  // A read notes its expected value before the strobe goes out.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_ufdc_host_model.cycle(a, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ufdc_host_model.cycle(a, d, 1'b1);
  endtask

  // Back to back received characters, pulse held for n cycles.
  task automatic push(input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      d = 8'($urandom);
      rxq.push_back(d);
      rx_push_i <= 1'b1;
      rx_data_i <= d;
    end
    @(posedge clk_i);
    rx_push_i <= 1'b0;
  endtask

  // Host writes n random characters into the transmit side.
  task automatic fill(input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      txq.push_back(d);
      wr(ufdc_pkg::ADDR_HOLD, d);
    end
  endtask

  task automatic pop1();
    @(posedge clk_i);
    tx_pop_i <= 1'b1;
    @(posedge clk_i);
    tx_pop_i <= 1'b0;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  // Read data stand one cycle after the strobe; score the oldest note.
  always @(posedge clk_i) begin
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        fail("read without a note");
      end else begin
        cmp(rdata_o, exp_q.pop_front(), "read data");
      end
    end
    rd_d <= bus.rd;
  end

  // Watchdog well beyond the thousand or so cycles the tests need.
  initial begin
    #100us;
    fail("timeout");
    give_verdict();
  end

  initial begin
    {nrst_i, tx_pop_i, rx_push_i, rx_timeout_i} = '0;
    ce_i = 1'b1;
    rx_data_i = 8'h00;
    void'($urandom(99));
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    lv(5'b01001);
    rd(ufdc_pkg::ADDR_CTRL, ufdc_pkg::CTRL_RESET);
    rd(ufdc_pkg::ADDR_STAT, 8'h00);
    done("reset");
    fill(1);
    lv(5'b00011);
    cmp({7'h0, tx_avail_o}, 8'h01, "tx avail");
    pop1();
    @(negedge clk_i);
    cmp(tx_data_o, txq.pop_front(), "tx data");
    lv(5'b01001);
    cmp({7'h0, tx_avail_o}, 8'h00, "tx avail");
    push(1);
    lv(5'b01100);
    rd(ufdc_pkg::ADDR_HOLD, rxq.pop_front());
    lv(5'b01001);
    done("fifo off");
    wr(ufdc_pkg::ADDR_CTRL, 8'hf8);
    rd(ufdc_pkg::ADDR_CTRL, 8'h00);
    u_ufdc_host_model.set_ctrl(8'hfe);
    rd(ufdc_pkg::ADDR_CTRL, 8'hf9);
    done("control");
    for (int c = 0; c < 4; c++) begin
      u_ufdc_host_model.set_ctrl(8'(c << 6) | 8'h0a);
      rxq.delete();
      push(rxtrig[c] - 1);
      lv(5'b01001);
      push(1);
      lv(5'b01100);
      push(65 - rxtrig[c]);
      rd(ufdc_pkg::ADDR_RXCNT, 8'h40);
    end
    done("rx trigger");
    u_ufdc_host_model.set_ctrl(8'h0a);
    rxq.delete();
    push(2);
    lv(5'b01001);
    @(posedge clk_i);
    rx_timeout_i <= 1'b1;
    @(posedge clk_i);
    rx_timeout_i <= 1'b0;
    lv(5'b01000);
    rd(ufdc_pkg::ADDR_HOLD, rxq.pop_front());
    lv(5'b01000);
    rd(ufdc_pkg::ADDR_HOLD, rxq.pop_front());
    lv(5'b01001);
    done("rx timeout");
    wr(ufdc_pkg::ADDR_CLR, 8'h17);
    rd(ufdc_pkg::ADDR_STAT, 8'h08);
    lv(5'b01001);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(ufdc_pkg::ADDR_IEN, 8'h1f);
    ce_i <= 1'b1;
    rd(ufdc_pkg::ADDR_IEN, 8'h00);
    wr(ufdc_pkg::ADDR_IEN, 8'h08);
    lv(5'b11001);
    rd(ufdc_pkg::ADDR_IEN, 8'h08);
    wr(ufdc_pkg::ADDR_CLR, 8'h08);
    lv(5'b01001);
    rd(ufdc_pkg::ADDR_STAT, 8'h00);
    rd(ufdc_pkg::ADDR_FLAG, 8'h05);
    rd(8'h20, 8'h00);
    done("interrupt");
    for (int c = 0; c < 4; c++) begin
      u_ufdc_host_model.set_ctrl(8'(c << 4) | 8'h0c);
      txq.delete();
      fill(txtrig[c] - 1);
      lv(5'b01001);
      fill(1);
      lv(5'b00001);
      fill(63 - txtrig[c]);
      lv(5'b00001);
      fill(1);
      lv(5'b00011);
      wr(ufdc_pkg::ADDR_HOLD, 8'h5a);
    end
    pop1();
    @(negedge clk_i);
    cmp(tx_data_o, txq.pop_front(), "tx head");
    rd(ufdc_pkg::ADDR_TXCNT, 8'h3f);
    rd(ufdc_pkg::ADDR_STAT, 8'h12);
    u_ufdc_host_model.set_ctrl(8'h04);
    rd(ufdc_pkg::ADDR_TXCNT, 8'h00);
    lv(5'b01001);
    done("tx trigger");
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule
